// ---- verilog/boot_loader_pkg.sv ----
// Boot loader constants and helpers
`default_nettype none
package boot_loader_pkg;
    // Clocking and timing
    localparam int CORE_MHZ = 250;
    localparam int WAIT_CLOCKS = 750000;
    localparam int LINK_EN_NS = 200;
    localparam int LINK_EN_CYCLES = (LINK_EN_NS * CORE_MHZ + 999) / 1000;
    localparam int SPI_REF_CORE_MHZ = 400;
    localparam int SPI_REF_KHZ = 2500;
    localparam int SPI_DIV = SPI_REF_CORE_MHZ * 1000 / SPI_REF_KHZ;
    localparam int SPI_HALF = SPI_DIV / 2;
    localparam int LINK_TX_HALF = 4;
    // Image format and checks
    localparam logic [31:0] CRC_POLY = 32'hedb88320;
    localparam logic [31:0] CRC_SEED = 32'hffffffff;
    localparam logic [31:0] CRC_SKIP = 32'h0d15ab1e;
    localparam logic [31:0] NULL_CHANEND = 32'h0000ff02;
    localparam logic [31:0] RAM_BASE = 32'h00000000;
    localparam logic [7:0] SPI_READ_CMD = 8'h03;
    localparam logic [23:0] SPI_START_ADDR = 24'h000000;
    localparam logic [7:0] END_TOKEN = 8'h01;
    // Bit 8 flags a control token
    localparam int SYM_W = 9;
    localparam int SYM_CTRL = 8;
    localparam int FIFO_DEPTH = 16;
    // Boot source straps
    localparam logic [1:0] SRC_LINK = 2'h2;
    localparam logic [1:0] SRC_SPI = 2'h3;

    typedef struct packed {
        logic [2:0] od;
        logic [11:0] f;
        logic [5:0] r;
    } pll_cfg_t;

    function automatic pll_cfg_t pll_lookup(input logic [1:0] ratio);
        unique case (ratio)
            2'h0: pll_lookup = '{od: 3'h1, f: 12'h07a, r: 6'h00};
            2'h3: pll_lookup = '{od: 3'h2, f: 12'h077, r: 6'h00};
            2'h2: pll_lookup = '{od: 3'h2, f: 12'h031, r: 6'h00};
            2'h1: pll_lookup = '{od: 3'h2, f: 12'h017, r: 6'h00};
        endcase
    endfunction : pll_lookup

    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
        logic [31:0] x;
        x = c ^ {24'h000000, b};
        for (int i = 0; i < 8; i++) begin
            x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
        end
        crc_byte = x;
    endfunction : crc_byte
endpackage : boot_loader_pkg
`default_nettype wire

// ---- verilog/sym_fifo.sv ----
// Valid/ready FIFO
`default_nettype none
module sym_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } fifo_t;

    fifo_t r_reg;
    fifo_t r_next;
    logic push;
    logic pop;

    assign in_ready_o = r_reg.cnt != (AW + 1)'(DEPTH);
    assign out_valid_o = r_reg.cnt != '0;
    assign out_data_o = r_reg.mem[r_reg.rp];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_comb begin
        r_next = r_reg;
        if (push) begin
            r_next.mem[r_reg.wp] = in_data_i;
            r_next.wp = (r_reg.wp == AW'(DEPTH - 1)) ? '0 : r_reg.wp + 1'b1;
        end
        if (pop) begin
            r_next.rp = (r_reg.rp == AW'(DEPTH - 1)) ? '0 : r_reg.rp + 1'b1;
        end
        r_next.cnt = r_reg.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
        if (srst_i) begin
            r_next.wp = '0;
            r_next.rp = '0;
            r_next.cnt = '0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        r_reg <= r_next;
    end
endmodule : sym_fifo
`default_nettype wire

// ---- verilog/boot_image_loader.sv ----
// Boot image loader top
//
// What this block does
// - Pins undriven in reset.
// - Wait 750,000 clocks, enable pulls, boot.
// - Straps pick debug wait, link or SPI.
// - Secure bit forces boot from OTP address zero.
// - Length, program, CRC; 0x0D15AB1E skips check.
// - Length and CRC LSB byte first.
// - Load and start at RAM address zero.
// - Reflected CRC-32 0xEDB88320, seed ones, inverted.
// - SPI master on four pins at core/160.
// - SPI read command, 24-bit zero address.
// - SPI mode 0.
// - SPI read data bytes LSB first; command and address MSB first.
// - Link enabled about 200 ns into boot.
// - Link enable drops pulls, drives outputs low.
// - Link: ack word, image, END, reply END, jump.
// - Ratio straps select PLL settings.
// - PLL fields 12, 6, 3 bits.
// - Resonator select high picks internal oscillator.
`default_nettype none
module boot_image_loader #(
    parameter int WAIT_CLOCKS = boot_loader_pkg::WAIT_CLOCKS,
    parameter int OTP_AW = 11
) (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic [2:0] boot_select_i,
    input wire logic ratio_strap0_i,
    input wire logic ratio_strap1_i,
    input wire logic resonator_select_n_i,
    input wire logic secure_boot_i,
    output logic gpio_pull_en_o,
    output logic clock_select_internal_o,
    output logic [2:0] pll_output_divider_o,
    output logic [11:0] pll_feedback_o,
    output logic [5:0] pll_input_divider_o,
    output logic spi_sclk_o,
    output logic spi_cs_n_o,
    output logic spi_mosi_o,
    output logic spi_oe_n_o,
    input wire logic spi_miso_i,
    output logic link_out_wire0_o,
    output logic link_out_wire1_o,
    output logic link_out_oe_n_o,
    output logic link_pulldown_en_o,
    input wire logic link_in_wire0_i,
    input wire logic link_in_wire1_i,
    output logic link_overrun_o,
    output logic otp_rd_o,
    output logic [OTP_AW-1:0] otp_addr_o,
    input wire logic [31:0] otp_data_i,
    output logic ram_we_o,
    output logic [31:0] ram_addr_o,
    output logic [31:0] ram_wdata_o,
    input wire logic ram_ready_i,
    output logic wait_debug_o,
    output logic crc_error_o,
    output logic boot_done_o,
    output logic jump_o,
    output logic [31:0] jump_addr_o
);
    typedef enum logic [3:0] {
        S_WAIT, S_DEBUG, S_LINK_DLY, S_LINK, S_SPI, S_OTP, S_CHECK, S_ACK, S_JUMP, S_DONE,
        S_FAIL
    } main_state_t;

    typedef enum logic [2:0] {P_DEST, P_LEN, P_PROG, P_CRC, P_END, P_CHECK} parse_state_t;

    typedef struct packed {
        main_state_t st;
        parse_state_t ph;
        logic is_link;
        logic [19:0] cnt;
        logic [6:0] strap_m;
        logic [6:0] strap_s;
        logic miso_m;
        logic miso_s;
        logic li0_m;
        logic li0_s;
        logic li0_d;
        logic li1_m;
        logic li1_s;
        logic [1:0] pidx;
        logic [31:0] word;
        logic [31:0] left;
        logic [31:0] waddr;
        logic [31:0] crc;
        logic [31:0] rx_crc;
        logic [31:0] ack_dest;
        logic push_valid;
        logic [8:0] push_data;
        logic spi_cmd;
        logic [5:0] bits;
        logic [31:0] sh;
        logic [7:0] rx;
        logic [8:0] lsh;
        logic [3:0] lcnt;
        logic [7:0] tx_sh;
        logic [2:0] tx_idx;
        logic [2:0] otp_left;
        logic [31:0] otp_word;
        logic pull_en;
        logic clk_int;
        boot_loader_pkg::pll_cfg_t pll;
        logic sclk;
        logic cs_n;
        logic mosi;
        logic spi_oe_n;
        logic lo0;
        logic lo1;
        logic link_oe_n;
        logic link_pd;
        logic overrun;
        logic otp_rd;
        logic [OTP_AW-1:0] otp_addr;
        logic ram_we;
        logic [31:0] ram_addr;
        logic [31:0] ram_wdata;
        logic wait_debug;
        logic crc_err;
        logic done;
        logic jump;
    } state_t;

    state_t r_reg;
    state_t r_next;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [8:0] fifo_out_data;

    sym_fifo #(.WIDTH(boot_loader_pkg::SYM_W), .DEPTH(boot_loader_pkg::FIFO_DEPTH)) u_fifo (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .in_valid_i(r_reg.push_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(r_reg.push_data),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_out_data)
    );

    // Drain only while loading and RAM idle
    assign fifo_pop = fifo_out_valid && (r_reg.ph != P_CHECK) && !r_reg.ram_we
        && (r_reg.st == S_LINK || r_reg.st == S_SPI || r_reg.st == S_OTP);

    always_comb begin
        logic [7:0] b;
        logic [31:0] w;
        logic tick;
        logic [8:0] sym;
        b = fifo_out_data[7:0];
        w = {b, r_reg.word[31:8]};
        tick = 1'b0;
        sym = '0;
        r_next = r_reg;
        r_next.jump = 1'b0;
        r_next.strap_m = {secure_boot_i, resonator_select_n_i, ratio_strap1_i,
            ratio_strap0_i, boot_select_i};
        r_next.strap_s = r_reg.strap_m;
        r_next.miso_m = spi_miso_i;
        r_next.miso_s = r_reg.miso_m;
        r_next.li0_m = link_in_wire0_i;
        r_next.li0_s = r_reg.li0_m;
        r_next.li0_d = r_reg.li0_s;
        r_next.li1_m = link_in_wire1_i;
        r_next.li1_s = r_reg.li1_m;
        if (r_reg.push_valid && fifo_in_ready) begin
            r_next.push_valid = 1'b0;
        end
        if (r_reg.ram_we && ram_ready_i) begin
            r_next.ram_we = 1'b0;
        end
        if (fifo_pop) begin
            if (!fifo_out_data[boot_loader_pkg::SYM_CTRL] || r_reg.ph == P_END) begin
                r_next.pidx = r_reg.pidx + 2'h1;
                r_next.word = w;
            end
            unique case (r_reg.ph)
                P_DEST: if (r_reg.pidx == 2'h3) begin
                    r_next.ack_dest = w;
                    r_next.ph = P_LEN;
                end
                P_LEN: begin
                    r_next.crc = boot_loader_pkg::crc_byte(r_reg.crc, b);
                    if (r_reg.pidx == 2'h3) begin
                        r_next.left = w;
                        r_next.ph = (w == '0) ? P_CRC : P_PROG;
                    end
                end
                P_PROG: begin
                    r_next.crc = boot_loader_pkg::crc_byte(r_reg.crc, b);
                    if (r_reg.pidx == 2'h3) begin
                        r_next.ram_we = 1'b1;
                        r_next.ram_wdata = w;
                        r_next.ram_addr = r_reg.waddr;
                        r_next.waddr = r_reg.waddr + 32'h1;
                        r_next.left = r_reg.left - 32'h1;
                        if (r_reg.left == 32'h1) begin
                            r_next.ph = P_CRC;
                        end
                    end
                end
                P_CRC: if (r_reg.pidx == 2'h3) begin
                    r_next.rx_crc = w;
                    r_next.ph = r_reg.is_link ? P_END : P_CHECK;
                end
                P_END: begin
                    r_next.pidx = 2'h0;
                    if (fifo_out_data == {1'b1, boot_loader_pkg::END_TOKEN}) begin
                        r_next.ph = P_CHECK;
                    end
                end
                P_CHECK: ;
            endcase
        end
        unique case (r_reg.st)
            S_WAIT: begin
                r_next.cnt = r_reg.cnt + 20'h1;
                if (r_reg.cnt == 20'(WAIT_CLOCKS - 1)) begin
                    r_next.cnt = '0;
                    r_next.pull_en = 1'b1;
                    r_next.clk_int = r_reg.strap_s[5];
                    r_next.pll = boot_loader_pkg::pll_lookup(
                        r_reg.strap_s[4:3]);
                    if (r_reg.strap_s[6]) begin
                        r_next.st = S_OTP;
                        r_next.otp_addr = '0;
                    end else if (r_reg.strap_s[1:0] == boot_loader_pkg::SRC_LINK) begin
                        r_next.st = S_LINK_DLY;
                        r_next.is_link = 1'b1;
                        r_next.ph = P_DEST;
                    end else if (r_reg.strap_s[1:0] == boot_loader_pkg::SRC_SPI) begin
                        r_next.st = S_SPI;
                        r_next.cs_n = 1'b0;
                        r_next.spi_oe_n = 1'b0;
                        r_next.spi_cmd = 1'b1;
                        r_next.bits = 6'd32;
                        r_next.mosi = boot_loader_pkg::SPI_READ_CMD[7];
                        r_next.sh = {boot_loader_pkg::SPI_READ_CMD[6:0],
                            boot_loader_pkg::SPI_START_ADDR, 1'b0};
                    end else begin
                        r_next.st = S_DEBUG;
                        r_next.wait_debug = 1'b1;
                    end
                end
            end
            S_LINK_DLY: begin
                r_next.cnt = r_reg.cnt + 20'h1;
                if (r_reg.cnt == 20'(boot_loader_pkg::LINK_EN_CYCLES - 1)) begin
                    r_next.cnt = '0;
                    r_next.link_pd = 1'b0;
                    r_next.link_oe_n = 1'b0;
                    r_next.st = S_LINK;
                end
            end
            S_LINK: begin
                // Strobe rise samples data
                if (r_reg.li0_s && !r_reg.li0_d) begin
                    sym = {r_reg.li1_s, r_reg.lsh[8:1]};
                    r_next.lsh = sym;
                    r_next.lcnt = r_reg.lcnt + 4'h1;
                    if (r_reg.lcnt == 4'h8) begin
                        r_next.lcnt = '0;
                        r_next.overrun = r_reg.overrun | r_reg.push_valid;
                        r_next.push_valid = 1'b1;
                        r_next.push_data = {sym[0], sym[8:1]};
                    end
                end
                if (r_reg.ph == P_CHECK) begin
                    r_next.st = S_CHECK;
                end
            end
            S_SPI: begin
                tick = r_reg.cnt == 20'(boot_loader_pkg::SPI_HALF - 1);
                r_next.cnt = tick ? '0 : r_reg.cnt + 20'h1;
                if (!r_reg.sclk && r_reg.ph == P_CHECK) begin
                    r_next.cs_n = 1'b1;
                    r_next.st = S_CHECK;
                end else if (tick && !r_reg.sclk && r_reg.bits == '0) begin
                    if (r_reg.spi_cmd) begin
                        r_next.spi_cmd = 1'b0;
                        r_next.bits = 6'd8;
                    end else if (!r_reg.push_valid) begin // back-pressure holds clock low
                        r_next.push_valid = 1'b1;
                        r_next.push_data = {1'b0, r_reg.rx};
                        r_next.bits = 6'd8;
                    end else begin
                        r_next.cnt = r_reg.cnt;
                    end
                end else if (tick && !r_reg.sclk) begin
                    r_next.sclk = 1'b1;
                    r_next.rx = {r_reg.miso_s, r_reg.rx[7:1]};
                    r_next.bits = r_reg.bits - 6'h1;
                end else if (tick) begin
                    r_next.sclk = 1'b0;
                    r_next.mosi = r_reg.sh[31];
                    r_next.sh = {r_reg.sh[30:0], 1'b0};
                end
            end
            S_OTP: begin
                r_next.otp_rd = 1'b0;
                if (r_reg.otp_rd) begin
                    r_next.otp_word = otp_data_i;
                    r_next.otp_left = 3'h4;
                    r_next.otp_addr = r_reg.otp_addr + 1'b1;
                end else if (r_reg.otp_left != '0 && !r_reg.push_valid) begin
                    r_next.push_valid = 1'b1;
                    r_next.push_data = {1'b0, r_reg.otp_word[7:0]};
                    r_next.otp_word = {8'h00, r_reg.otp_word[31:8]};
                    r_next.otp_left = r_reg.otp_left - 3'h1;
                end else if (r_reg.otp_left == '0 && r_reg.ph != P_CHECK) begin
                    r_next.otp_rd = 1'b1;
                end
                if (r_reg.ph == P_CHECK && !r_reg.otp_rd) begin
                    r_next.st = S_CHECK;
                end
            end
            S_CHECK: begin
                if (r_reg.ram_we) begin
                    r_next.st = S_CHECK;
                end else if (r_reg.rx_crc != boot_loader_pkg::CRC_SKIP
                        && r_reg.rx_crc != ~r_reg.crc) begin
                    r_next.crc_err = 1'b1;
                    r_next.st = S_FAIL;
                end else if (r_reg.is_link
                        && r_reg.ack_dest != boot_loader_pkg::NULL_CHANEND) begin
                    r_next.st = S_ACK;
                    r_next.cnt = '0;
                    r_next.tx_idx = '0;
                    r_next.bits = '0;
                end else begin
                    r_next.st = S_JUMP;
                end
            end
            S_ACK: begin
                // Dest bytes then END
                r_next.cnt = r_reg.cnt + 20'h1;
                if (r_reg.cnt == 20'(boot_loader_pkg::LINK_TX_HALF - 1)) begin
                    r_next.cnt = '0;
                    if (r_reg.lo0) begin
                        r_next.lo0 = 1'b0;
                        r_next.lo1 = r_reg.tx_sh[0];
                        r_next.tx_sh = {1'b0, r_reg.tx_sh[7:1]};
                        r_next.bits = r_reg.bits - 6'h1;
                    end else if (r_reg.bits != '0) begin
                        r_next.lo0 = 1'b1;
                    end else if (r_reg.tx_idx == 3'h5) begin
                        r_next.lo1 = 1'b0;
                        r_next.st = S_JUMP;
                    end else begin
                        r_next.lo1 = r_reg.tx_idx == 3'h4;
                        r_next.tx_sh = (r_reg.tx_idx == 3'h4) ? boot_loader_pkg::END_TOKEN
                            : r_reg.ack_dest[8 * r_reg.tx_idx[1:0] +: 8];
                        r_next.tx_idx = r_reg.tx_idx + 3'h1;
                        r_next.bits = 6'd9;
                    end
                end
            end
            S_JUMP: begin
                r_next.jump = 1'b1;
                r_next.done = 1'b1;
                r_next.st = S_DONE;
            end
            S_DEBUG, S_DONE, S_FAIL: ;
        endcase
        if (srst_i) begin
            r_next = '0;
            r_next.st = S_WAIT;
            r_next.ph = P_LEN;
            r_next.crc = boot_loader_pkg::CRC_SEED;
            r_next.waddr = boot_loader_pkg::RAM_BASE;
            r_next.cs_n = 1'b1;
            r_next.spi_oe_n = 1'b1;
            r_next.link_oe_n = 1'b1;
            r_next.link_pd = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        r_reg <= r_next;
    end

    assign gpio_pull_en_o = r_reg.pull_en;
    assign clock_select_internal_o = r_reg.clk_int;
    assign pll_output_divider_o = r_reg.pll.od;
    assign pll_feedback_o = r_reg.pll.f;
    assign pll_input_divider_o = r_reg.pll.r;
    assign spi_sclk_o = r_reg.sclk;
    assign spi_cs_n_o = r_reg.cs_n;
    assign spi_mosi_o = r_reg.mosi;
    assign spi_oe_n_o = r_reg.spi_oe_n;
    assign link_out_wire0_o = r_reg.lo0;
    assign link_out_wire1_o = r_reg.lo1;
    assign link_out_oe_n_o = r_reg.link_oe_n;
    assign link_pulldown_en_o = r_reg.link_pd;
    assign link_overrun_o = r_reg.overrun;
    assign otp_rd_o = r_reg.otp_rd;
    assign otp_addr_o = r_reg.otp_addr;
    assign ram_we_o = r_reg.ram_we;
    assign ram_addr_o = r_reg.ram_addr;
    assign ram_wdata_o = r_reg.ram_wdata;
    assign wait_debug_o = r_reg.wait_debug;
    assign crc_error_o = r_reg.crc_err;
    assign boot_done_o = r_reg.done;
    assign jump_o = r_reg.jump;
    assign jump_addr_o = boot_loader_pkg::RAM_BASE;
endmodule : boot_image_loader
`default_nettype wire

// ---- verif/boot_loader_checker.sv ----
// Boot loader checker
`default_nettype none
module boot_loader_checker #(parameter int WAIT_CLOCKS = 20) (
    input wire logic core_clk_i, srst_i, ratio_strap0_i, ratio_strap1_i, ram_ready_i,
    input wire logic gpio_pull_en_o, spi_sclk_o, spi_cs_n_o, spi_mosi_o, spi_oe_n_o,
    input wire logic link_out_oe_n_o, ram_we_o, jump_o, boot_done_o, crc_error_o,
    input wire logic wait_debug_o,
    input wire logic [2:0] pll_output_divider_o,
    input wire logic [11:0] pll_feedback_o,
    input wire logic [31:0] ram_addr_o, ram_wdata_o, jump_addr_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    logic [31:0] cnt_reg;
    logic [7:0] hi_reg;
    logic [1:0] r;
    logic [14:0] pll_exp;
    assign r = {ratio_strap1_i, ratio_strap0_i};
    assign pll_exp = r[1] ? (r[0] ? 15'h2077 : 15'h2031) : (r[0] ? 15'h2017 : 15'h107a);
    always_ff @(posedge core_clk_i) begin
        cnt_reg <= srst_i ? 32'h0 : cnt_reg + 32'h1;
        hi_reg <= spi_sclk_o ? hi_reg + 8'h1 : 8'h0;
    end
    a_reset_undriven: assert property (disable iff (1'b0)
        $past(srst_i) |-> spi_oe_n_o && link_out_oe_n_o && !gpio_pull_en_o) else $error("pins driven");
    a_pull_wait: assert property ($rose(gpio_pull_en_o) |->
        cnt_reg inside {[WAIT_CLOCKS - 1:WAIT_CLOCKS + 2]}) else $error("pull timing");
    a_pll_table: assert property (gpio_pull_en_o |->
        {pll_output_divider_o, pll_feedback_o} == pll_exp) else $error("pll setting");
    a_sclk_idle: assert property (spi_cs_n_o |-> !spi_sclk_o) else $error("sclk idle");
    a_sclk_rate: assert property ($fell(spi_sclk_o) |->
        hi_reg == boot_loader_pkg::SPI_HALF) else $error("sclk high time");
    a_mosi_steady: assert property (spi_sclk_o && $past(spi_sclk_o) |->
        $stable(spi_mosi_o)) else $error("mosi moved");
    a_ram_hold: assert property (ram_we_o && !ram_ready_i |=> ram_we_o &&
        $stable(ram_addr_o) && $stable(ram_wdata_o)) else $error("ram write dropped");
    a_jump_zero: assert property (jump_o |-> jump_addr_o == 32'h0 ##1
        !jump_o && boot_done_o) else $error("jump");
    a_no_run_bad: assert property (crc_error_o |-> !jump_o && !boot_done_o)
        else $error("jump after crc error");
    c_jump: cover property (jump_o);
    c_crc_bad: cover property ($rose(crc_error_o));
    c_ram_stall: cover property (ram_we_o && !ram_ready_i);
    c_debug: cover property (wait_debug_o);
endmodule : boot_loader_checker
bind boot_image_loader boot_loader_checker #(.WAIT_CLOCKS(WAIT_CLOCKS)) u_chk (
    .core_clk_i, .srst_i, .ratio_strap0_i, .ratio_strap1_i, .ram_ready_i, .gpio_pull_en_o,
    .spi_sclk_o, .spi_cs_n_o, .spi_mosi_o, .spi_oe_n_o, .link_out_oe_n_o, .ram_we_o, .jump_o,
    .boot_done_o, .crc_error_o, .wait_debug_o, .pll_output_divider_o, .pll_feedback_o,
    .ram_addr_o, .ram_wdata_o, .jump_addr_o);
`default_nettype wire

// ---- verif/spi_flash_model.sv ----
// SPI flash model
`default_nettype none
module spi_flash_model (
    input wire logic sclk_i, cs_n_i, mosi_i,
    output logic miso_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:63];
    logic [31:0] cmd_reg;
    int n = 0;
    initial miso_o = 1'b0;
    always @(posedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) n <= 0;
        else begin
            if (n < 32) cmd_reg <= {cmd_reg[30:0], mosi_i};
            n <= n + 1;
        end
    end
    // Released line shows the inverse of its last level
    always @(negedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) miso_o <= ~miso_o;
        else if (n >= 32) miso_o <= mem[(n - 32) / 8][(n - 32) % 8];
    end
endmodule : spi_flash_model
`default_nettype wire

// ---- verif/testbench.sv ----
// Boot loader bench
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i = 1'b0, srst_i = 1'b1, ram_ready_i = 1'b0, resonator_select_n_i = 1'b0;
    logic ratio_strap0_i = 1'b0, ratio_strap1_i = 1'b0, secure_boot_i = 1'b0, spi_miso_i;
    logic link_in_wire0_i = 1'b0, link_in_wire1_i = 1'b0;
    logic [2:0] boot_select_i = 3'h0, pll_output_divider_o;
    logic [31:0] otp_data_i = 32'h0, crc, w, ram_addr_o, ram_wdata_o, jump_addr_o;
    logic gpio_pull_en_o, clock_select_internal_o, spi_sclk_o, spi_cs_n_o, spi_mosi_o;
    logic spi_oe_n_o, link_out_wire0_o, link_out_wire1_o, link_out_oe_n_o, link_pulldown_en_o;
    logic ram_we_o, wait_debug_o, crc_error_o, boot_done_o, jump_o;
    logic [11:0] pll_feedback_o;
    logic [15:0] lfsr = 16'h6a4e, rdy = 16'h6a4e;
    logic [7:0] img[$];
    logic [63:0] exp_q[$];
    int errors = 0, checks = 0;
    localparam logic [2:0] SEL [5] = '{3'h7, 3'h2, 3'h6, 3'h0, 3'h5};
    localparam logic [11:0] FB [4] = '{12'h07a, 12'h017, 12'h031, 12'h077};
    boot_image_loader #(.WAIT_CLOCKS(20)) u_dut (
        .core_clk_i, .srst_i, .boot_select_i, .ratio_strap0_i, .ratio_strap1_i,
        .resonator_select_n_i, .secure_boot_i, .gpio_pull_en_o, .clock_select_internal_o,
        .pll_output_divider_o, .pll_feedback_o, .pll_input_divider_o(), .spi_sclk_o,
        .spi_cs_n_o, .spi_mosi_o, .spi_oe_n_o, .spi_miso_i, .link_out_wire0_o,
        .link_out_wire1_o, .link_out_oe_n_o, .link_pulldown_en_o, .link_in_wire0_i,
        .link_in_wire1_i, .link_overrun_o(), .otp_rd_o(), .otp_addr_o(), .otp_data_i,
        .ram_we_o, .ram_addr_o, .ram_wdata_o, .ram_ready_i, .wait_debug_o, .crc_error_o,
        .boot_done_o, .jump_o, .jump_addr_o);
    spi_flash_model u_flash (.sclk_i(spi_sclk_o), .cs_n_i(spi_cs_n_o), .mosi_i(spi_mosi_o),
        .miso_o(spi_miso_i));
    function automatic logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : nxt
    function automatic logic [31:0] crc8(input logic [31:0] c, input logic [7:0] b);
        c = c ^ {24'h0, b};
        for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
        return c;
    endfunction : crc8
    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        checks++;
        if (seen !== want) begin
            errors++;
            $display("FAIL %0t seen %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic put(input logic [31:0] v, input bit c);
        for (int b = 0; b < 4; b++) begin
            img.push_back(v[8*b+:8]);
            if (c) crc = crc8(crc, v[8*b+:8]);
        end
    endtask : put
    task automatic sym(input logic [8:0] s);
        for (int i = 0; i < 9; i++) begin
            link_in_wire1_i = s[i];
            #32 link_in_wire0_i = 1'b1;
            #32 link_in_wire0_i = 1'b0;
        end
        link_in_wire1_i = 1'b0;
    endtask : sym
    task automatic results;
        if (errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results
    always #2 core_clk_i = ~core_clk_i;
    // Random RAM stalls
    always @(negedge core_clk_i) begin
        rdy = nxt(rdy);
        ram_ready_i = rdy[0] | rdy[1];
        if (ram_we_o && ram_ready_i) check({ram_addr_o, ram_wdata_o}, exp_q.pop_front());
    end
    initial begin
        #300us;
        errors++;
        results();
    end
    initial begin
        for (int run = 0; run < 5; run++) begin
            @(negedge core_clk_i);
            srst_i = 1'b1;
            boot_select_i = SEL[run];
            {ratio_strap1_i, ratio_strap0_i} = 2'(run);
            resonator_select_n_i = run[0];
            img.delete();
            crc = 32'hffffffff;
            if (SEL[run][1]) begin
                if (!SEL[run][0]) put(32'h0000ff02, 1'b0);
                put(run == 0 ? 32'h2 : 32'h1, 1'b1);
                for (int k = 0; k <= (run == 0 ? 1 : 0); k++) begin
                    lfsr = nxt(lfsr);
                    w = {lfsr, ~lfsr};
                    exp_q.push_back({32'(k), w});
                    put(w, 1'b1);
                end
                put(run == 1 ? 32'h0d15ab1e : ~crc ^ 32'(run == 2), 1'b0);
            end
            foreach (img[i]) u_flash.mem[i] = img[i];
            repeat (2) @(negedge core_clk_i);
            srst_i = 1'b0;
            repeat (25) @(negedge core_clk_i);
            check(64'(gpio_pull_en_o), 64'h1);
            check(64'({pll_output_divider_o, pll_feedback_o}),
                64'({run % 4 == 0 ? 3'h1 : 3'h2, FB[run % 4]}));
            check(64'(clock_select_internal_o), 64'(run[0]));
            if (!SEL[run][1]) begin
                check(64'({wait_debug_o, spi_cs_n_o, link_out_oe_n_o}), 64'h7);
            end else begin
                if (!SEL[run][0]) begin
                    repeat (60) @(negedge core_clk_i);
                    check(64'({link_out_oe_n_o, link_pulldown_en_o, link_out_wire0_o}),
                        64'h0);
                    foreach (img[i]) sym({img[i], 1'b0});
                    sym(9'h003);
                end
                for (int t = 0; t < 40000 && !jump_o && !crc_error_o; t++) @(negedge core_clk_i);
                check(64'({jump_o, crc_error_o}), run == 2 ? 64'h1 : 64'h2);
                if (SEL[run][0]) check(64'(u_flash.cmd_reg), 64'h03000000);
                check(64'(exp_q.size()), 64'h0);
            end
        end
        results();
    end
endmodule : testbench
`default_nettype wire
